// ---- include/ppr_pkg.sv ----
// ----------------------------------------------------------------
// shared constants of the printer parallel link
// ----------------------------------------------------------------
package ppr_pkg;

  // system clock rate
  localparam int CLK_MHZ = 40;

  // ----------------------------------------------------------------
  // link timing, figures in ns, cycles derived from the clock rate
  // ----------------------------------------------------------------
  // least latch pulse width, rounded up
  localparam int STROBE_MIN_NS = 500;
  localparam int STROBE_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
  // accept pulse width, approximate, rounded down
  localparam int ACCEPT_NS = 5000;
  localparam int ACCEPT_CYC = (ACCEPT_NS * CLK_MHZ) / 1000;
  // least restart pulse width, rounded up
  localparam int RESTART_MIN_NS = 50000;
  localparam int RESTART_CYC = (RESTART_MIN_NS * CLK_MHZ + 999) / 1000;
  // least character period at 1000 characters per second
  localparam int CHAR_PERIOD_NS = 1000000;
  localparam int CHAR_CYC_DEF = (CHAR_PERIOD_NS * CLK_MHZ + 999) / 1000;
  // data setup and hold around the latch pulse
  localparam int SETUP_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // character handling
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam int LINE_CHARS_DEF = 80;

  // ----------------------------------------------------------------
  // host register map, byte addresses on the wishbone bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  // control bits
  localparam int CTRL_AUTOFEED = 0;
  localparam int CTRL_SELECT = 1;
  localparam int CTRL_RESTART = 2;
  localparam int CTRL_W = 2;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_PAPER = 1;
  localparam int ST_SEL = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_PEND = 4;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01, DS_ENTRY = 5'h02, DS_PRINT = 5'h04,
    DS_WAIT = 5'h08, DS_ACCEPT = 5'h10
  } ppr_dev_state_t;

  typedef enum logic [4:0] {
    HS_IDLE = 5'h01, HS_SETUP = 5'h02, HS_STROBE = 5'h04,
    HS_HOLD = 5'h08, HS_WAIT = 5'h10
  } ppr_host_state_t;

  // pins seen by the printer end, all from outside its clock
  typedef struct packed {
    logic strobe_n;
    logic restart_n;
    logic autofeed_n;
    logic host_select_n;
    logic [7:0] data;
    logic sw_1_2;
    logic sw_1_3;
    logic sw_1_8;
    logic sw_2_3;
    logic paper_empty;
    logic offline;
    logic mech_error;
  } ppr_dev_pins_t;

  localparam ppr_dev_pins_t DEV_PINS_RST = '{strobe_n: 1'b1, restart_n: 1'b1,
    autofeed_n: 1'b1, host_select_n: 1'b1, default: '0};

  // pins seen by the host end
  typedef struct packed {
    logic busy;
    logic accept_n;
    logic paper_out;
    logic selected;
    logic fault_n;
  } ppr_host_pins_t;

  localparam ppr_host_pins_t HOST_PINS_RST = '{busy: 1'b1, accept_n: 1'b1,
    paper_out: 1'b0, selected: 1'b0, fault_n: 1'b1};

endpackage

// ---- include/ppr_if.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// parallel printer link between host adapter and printer
// ----------------------------------------------------------------
interface ppr_if;
  logic [7:0] data;
  logic strobe_n;
  logic autofeed_n;
  logic restart_n;
  logic host_select_n;
  logic accept_pulse_n;
  logic busy;
  logic paper_out;
  logic selected_status;
  logic fault_n;

  modport device (
    input data, strobe_n, autofeed_n, restart_n, host_select_n,
    output accept_pulse_n, busy, paper_out, selected_status, fault_n
  );

  modport host (
    output data, strobe_n, autofeed_n, restart_n, host_select_n,
    input accept_pulse_n, busy, paper_out, selected_status, fault_n
  );
endinterface

// ---- rtl/ppr_device.sv ----
`timescale 1ns/100ps
module ppr_device
  import ppr_pkg::*;
#(
  parameter int LINE_CHARS = LINE_CHARS_DEF
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // link to the host
  ppr_if.device link,
  // configuration switches, high means on
  input wire logic i_config_switch_1_2,
  input wire logic i_config_switch_1_3,
  input wire logic i_config_switch_1_8,
  input wire logic i_config_switch_2_3,
  // mechanism status
  input wire logic i_paper_empty,
  input wire logic i_offline,
  input wire logic i_mech_error,
  // print mechanism
  output logic o_print_req,
  output logic [7:0] o_print_char,
  output logic o_line_feed,
  input wire logic i_print_done,
  output logic o_buffer_clear
);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  localparam int COL_W = $clog2(LINE_CHARS);
  localparam int ACC_W = $clog2(ACCEPT_CYC + 1);
  localparam logic [COL_W-1:0] COL_LAST = COL_W'(LINE_CHARS - 1);
  localparam logic [ACC_W-1:0] ACC_LOAD = ACC_W'(ACCEPT_CYC - 1);

  ppr_dev_pins_t pins_in;
  ppr_dev_pins_t meta_r;
  ppr_dev_pins_t s;

  assign pins_in = '{strobe_n: link.strobe_n, restart_n: link.restart_n,
    autofeed_n: link.autofeed_n, host_select_n: link.host_select_n,
    data: link.data, sw_1_2: i_config_switch_1_2, sw_1_3: i_config_switch_1_3,
    sw_1_8: i_config_switch_1_8, sw_2_3: i_config_switch_2_3,
    paper_empty: i_paper_empty, offline: i_offline, mech_error: i_mech_error};

  // two flops on every pin; only the second stage is read
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= DEV_PINS_RST;
      s <= DEV_PINS_RST;
    end
    else
    begin
      meta_r <= pins_in;
      s <= meta_r;
    end
  end

  // ----------------------------------------------------------------
  // effective levels after the switch overrides
  // ----------------------------------------------------------------
  logic restart;
  logic sel_ok;
  logic autofeed;
  logic trouble;
  logic strobe_d_r;
  logic strobe_fall;
  logic start;

  assign restart = !s.restart_n;
  assign sel_ok = s.sw_1_8 || !s.host_select_n;
  assign autofeed = s.sw_2_3 || !s.autofeed_n;
  assign trouble = s.paper_empty || s.offline || s.mech_error;
  assign strobe_fall = strobe_d_r && !s.strobe_n;
  // a latch pulse while deselected or in trouble is ignored
  assign start = strobe_fall && sel_ok && !trouble && !restart;

  // previous latch level for edge detection
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      strobe_d_r <= 1'b1;
    else
      strobe_d_r <= s.strobe_n;
  end

  // ----------------------------------------------------------------
  // character intake sequence
  // ----------------------------------------------------------------
  ppr_dev_state_t state_r;
  logic [7:0] char_r;
  logic [ACC_W-1:0] acc_cnt_r;
  logic [COL_W-1:0] col_r;
  logic accept_n_r;
  logic print_req_r;
  logic line_feed_r;
  logic acc_end;

  assign acc_end = (state_r == DS_ACCEPT) && (acc_cnt_r == '0);

  // restart acts as a synchronous return to the initial state
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= DS_IDLE;
      acc_cnt_r <= '0;
    end
    else if (restart)
    begin
      state_r <= DS_IDLE;
      acc_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        DS_IDLE:
          if (start)
            state_r <= DS_ENTRY;
        DS_ENTRY:
          if (s.strobe_n)
            state_r <= DS_PRINT;
        DS_PRINT:
          state_r <= DS_WAIT;
        DS_WAIT:
          if (i_print_done)
          begin
            state_r <= DS_ACCEPT;
            acc_cnt_r <= ACC_LOAD;
          end
        DS_ACCEPT:
          if (acc_cnt_r == '0)
            state_r <= DS_IDLE;
          else
            acc_cnt_r <= acc_cnt_r - 1'b1;
        default:
          state_r <= DS_IDLE;
      endcase
    end
  end

  // data follows the lines for as long as the latch pulse is low
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      char_r <= '0;
    else if (start || (state_r == DS_ENTRY && !s.strobe_n))
      char_r <= s.data;
  end

  // one request per character to the mechanism
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      print_req_r <= 1'b0;
    else
      print_req_r <= (state_r == DS_PRINT) && !restart;
  end

  // ----------------------------------------------------------------
  // line end handling: carriage return or full line buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      col_r <= '0;
      line_feed_r <= 1'b0;
    end
    else if (restart)
    begin
      col_r <= '0;
      line_feed_r <= 1'b0;
    end
    else if (state_r == DS_WAIT && i_print_done)
    begin
      if (char_r == CHAR_CR)
      begin
        col_r <= '0;
        line_feed_r <= !s.sw_1_2 || autofeed;
      end
      else if (col_r == COL_LAST)
      begin
        col_r <= '0;
        line_feed_r <= !s.sw_1_3 || autofeed;
      end
      else
      begin
        col_r <= col_r + 1'b1;
        line_feed_r <= 1'b0;
      end
    end
    else
      line_feed_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // status towards the host
  // ----------------------------------------------------------------
  logic busy_r;
  logic paper_r;
  logic selected_r;
  logic fault_n_r;
  logic clear_r;

  // accept pulse is low exactly while counting down
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      accept_n_r <= 1'b1;
    else if (restart)
      accept_n_r <= 1'b1;
    else if (state_r == DS_WAIT && i_print_done)
      accept_n_r <= 1'b0;
    else if (acc_end)
      accept_n_r <= 1'b1;
  end

  // busy rises with the latch fall and drops as the accept pulse ends
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      busy_r <= 1'b1;
    else
      busy_r <= trouble || restart || start
        || (state_r != DS_IDLE && !acc_end);
  end

  // paper, selection and fault flags
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      paper_r <= 1'b0;
      selected_r <= 1'b0;
      fault_n_r <= 1'b1;
      clear_r <= 1'b0;
    end
    else
    begin
      paper_r <= s.paper_empty;
      selected_r <= sel_ok && !s.offline;
      fault_n_r <= !trouble;
      clear_r <= restart;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign link.accept_pulse_n = accept_n_r;
  assign link.busy = busy_r;
  assign link.paper_out = paper_r;
  assign link.selected_status = selected_r;
  assign link.fault_n = fault_n_r;
  assign o_print_req = print_req_r;
  assign o_print_char = char_r;
  assign o_line_feed = line_feed_r;
  assign o_buffer_clear = clear_r;

endmodule

// ---- rtl/ppr_host.sv ----
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module ppr_host
  import ppr_pkg::*;
#(
  parameter int CHAR_CYC = CHAR_CYC_DEF
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // interrupt
  output logic o_irq,
  // link to the printer
  ppr_if.host link
);

  // ----------------------------------------------------------------
  // synchroniser on printer outputs
  // ----------------------------------------------------------------
  localparam int GAP_W = $clog2(CHAR_CYC + 1);
  localparam int CNT_W = $clog2(RESTART_CYC + 2);
  ppr_host_pins_t meta_r;
  ppr_host_pins_t s;
  ppr_host_pins_t pins_in;

  assign pins_in = '{busy: link.busy, accept_n: link.accept_pulse_n,
    paper_out: link.paper_out, selected: link.selected_status,
    fault_n: link.fault_n};

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= HOST_PINS_RST;
      s <= HOST_PINS_RST;
    end
    else
    begin
      meta_r <= pins_in;
      s <= meta_r;
    end
  end

  // ----------------------------------------------------------------
  // bus decode: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  logic ack_r;
  logic acc;
  logic wr;
  logic rd_irq;
  logic [CTRL_W-1:0] ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  logic pend_r;
  logic [7:0] tx_r;
  logic [CNT_W-1:0] rst_cnt_r;
  logic fault_d_r;
  logic [31:0] rdat_r;

  assign acc = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr = acc && i_wb_we && i_wb_sel[0];
  assign rd_irq = acc && !i_wb_we && (i_wb_adr == REG_IRQ_STAT);

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ack_r <= 1'b0;
    else
      ack_r <= acc;
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdat_r <= '0;
    else if (acc)
    begin
      rdat_r <= '0;
      case (i_wb_adr)
        REG_DATA: rdat_r[7:0] <= tx_r;
        REG_CTRL: rdat_r[CTRL_W-1:0] <= ctrl_r;
        REG_STATUS:
        begin
          rdat_r[ST_BUSY] <= s.busy;
          rdat_r[ST_PAPER] <= s.paper_out;
          rdat_r[ST_SEL] <= s.selected;
          rdat_r[ST_FAULT] <= !s.fault_n;
          rdat_r[ST_PEND] <= pend_r;
        end
        REG_IRQ_STAT: rdat_r[IRQ_W-1:0] <= irq_stat_r;
        REG_IRQ_MASK: rdat_r[IRQ_W-1:0] <= irq_mask_r;
        default: rdat_r <= '0;
      endcase
    end
  end

  // control and mask registers; restart bit only starts a pulse
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_r <= '0;
      irq_mask_r <= '0;
    end
    else if (wr && i_wb_adr == REG_CTRL)
      ctrl_r <= i_wb_dat[CTRL_W-1:0];
    else if (wr && i_wb_adr == REG_IRQ_MASK)
      irq_mask_r <= i_wb_dat[IRQ_W-1:0];
  end

  // restart pulse held one cycle past the least width
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_cnt_r <= '0;
    else if (wr && i_wb_adr == REG_CTRL && i_wb_dat[CTRL_RESTART])
      rst_cnt_r <= CNT_W'(RESTART_CYC + 1);
    else if (rst_cnt_r != '0)
      rst_cnt_r <= rst_cnt_r - 1'b1;
  end

  // ----------------------------------------------------------------
  // character send sequence
  // ----------------------------------------------------------------
  ppr_host_state_t st_r;
  logic [GAP_W-1:0] gap_r;
  logic [CNT_W-1:0] cnt_r;
  logic ack_seen_r;
  logic strobe_n_r;
  logic restarting;

  assign restarting = (rst_cnt_r != '0);

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_r <= HS_IDLE;
      cnt_r <= '0;
      strobe_n_r <= 1'b1;
      ack_seen_r <= 1'b0;
    end
    else if (restarting)
    begin
      st_r <= HS_IDLE;
      strobe_n_r <= 1'b1;
    end
    else
    begin
      case (st_r)
        HS_IDLE:
          if (pend_r && !s.busy && gap_r == '0)
          begin
            st_r <= HS_SETUP;
            cnt_r <= CNT_W'(SETUP_CYC);
            ack_seen_r <= 1'b0;
          end
        HS_SETUP:
          if (cnt_r == '0)
          begin
            st_r <= HS_STROBE;
            strobe_n_r <= 1'b0;
            cnt_r <= CNT_W'(STROBE_CYC);
          end
          else
            cnt_r <= cnt_r - 1'b1;
        HS_STROBE:
          if (cnt_r == '0)
          begin
            st_r <= HS_HOLD;
            strobe_n_r <= 1'b1;
            cnt_r <= CNT_W'(SETUP_CYC);
          end
          else
            cnt_r <= cnt_r - 1'b1;
        HS_HOLD:
          if (cnt_r == '0)
            st_r <= HS_WAIT;
          else
            cnt_r <= cnt_r - 1'b1;
        HS_WAIT:
          if (ack_seen_r || !s.accept_n)
            st_r <= HS_IDLE;
        default:
          st_r <= HS_IDLE;
      endcase
      if (st_r != HS_IDLE && !s.accept_n)
        ack_seen_r <= 1'b1;
    end
  end

  // character spacing counter, started at each latch pulse
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      gap_r <= '0;
    else if (st_r == HS_SETUP && cnt_r == '0)
      gap_r <= GAP_W'(CHAR_CYC - 1);
    else if (gap_r != '0)
      gap_r <= gap_r - 1'b1;
  end

  // pending character; writes while pending are dropped
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pend_r <= 1'b0;
      tx_r <= '0;
    end
    else if (restarting || (st_r == HS_WAIT && (ack_seen_r || !s.accept_n)))
      pend_r <= 1'b0;
    else if (wr && i_wb_adr == REG_DATA && !pend_r)
    begin
      pend_r <= 1'b1;
      tx_r <= i_wb_dat[7:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, read clears, a new event wins over the clear
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_ev = '0;
    irq_ev[IRQ_DONE] = (st_r == HS_WAIT) && (ack_seen_r || !s.accept_n) && !restarting;
    irq_ev[IRQ_FAULT] = fault_d_r && !s.fault_n;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_stat_r <= '0;
      fault_d_r <= 1'b1;
    end
    else
    begin
      fault_d_r <= s.fault_n;
      irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | irq_ev;
    end
  end

  logic irq_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // link and bus outputs straight from flops
  logic autofeed_n_r;
  logic select_n_r;
  logic restart_n_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      autofeed_n_r <= 1'b1;
      select_n_r <= 1'b1;
      restart_n_r <= 1'b1;
    end
    else
    begin
      autofeed_n_r <= !ctrl_r[CTRL_AUTOFEED];
      select_n_r <= !ctrl_r[CTRL_SELECT];
      restart_n_r <= !restarting;
    end
  end

  assign link.data = tx_r;
  assign link.strobe_n = strobe_n_r;
  assign link.autofeed_n = autofeed_n_r;
  assign link.host_select_n = select_n_r;
  assign link.restart_n = restart_n_r;
  assign o_wb_dat = rdat_r;
  assign o_wb_ack = ack_r;
  assign o_irq = irq_r;

endmodule

// ---- bench/ppr_link_sva.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// link checker
// ----------------------------------------------------------------
module ppr_link_sva
  import ppr_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // link signals
  input wire logic [7:0] i_data,
  input wire logic i_strobe_n,
  input wire logic i_restart_n,
  input wire logic i_host_select_n,
  input wire logic i_accept_pulse_n,
  input wire logic i_busy,
  input wire logic i_paper_out,
  input wire logic i_fault_n
);
  int acc_cnt;
  int stb_cnt;
  int rst_cnt;

  // low-time counters; a width is judged on the edge where the line rises
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc_cnt <= 0;
      stb_cnt <= 0;
      rst_cnt <= 0;
    end
    else
    begin
      acc_cnt <= i_accept_pulse_n ? 0 : acc_cnt + 1;
      stb_cnt <= i_strobe_n ? 0 : stb_cnt + 1;
      rst_cnt <= i_restart_n ? 0 : rst_cnt + 1;
    end
  end

  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_acc_w; $rose(i_accept_pulse_n) |-> acc_cnt == ACCEPT_CYC; endproperty
  a_acc_w: assert property (p_acc_w) else $error("accept width");
  property p_stb_w; $rose(i_strobe_n) |-> stb_cnt == STROBE_CYC + 1; endproperty
  a_stb_w: assert property (p_stb_w) else $error("latch width");
  property p_rst_w; $rose(i_restart_n) |-> rst_cnt == RESTART_CYC + 1; endproperty
  a_rst_w: assert property (p_rst_w) else $error("restart width");
  property p_busy_acc; !i_accept_pulse_n |-> i_busy; endproperty
  a_busy_acc: assert property (p_busy_acc) else $error("busy low in accept");
  property p_entry; $fell(i_strobe_n) && !i_host_select_n |-> ##[1:4] i_busy; endproperty
  a_entry: assert property (p_entry) else $error("no busy on entry");
  property p_hold; !i_strobe_n |-> $stable(i_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved in latch");
  property p_paper; i_paper_out |-> ##[0:3] (!i_fault_n && i_busy); endproperty
  a_paper: assert property (p_paper) else $error("paper out not fault");
  property p_rst_idle; $fell(i_restart_n) |-> ##[2:5] (i_busy && i_accept_pulse_n); endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("restart not idle");
  property p_pace; $fell(i_strobe_n) |-> i_accept_pulse_n; endproperty
  a_pace: assert property (p_pace) else $error("latch during accept");

  c_acc: cover property ($rose(i_accept_pulse_n));
  c_rst: cover property ($fell(i_restart_n));
  c_paper: cover property ($rose(i_paper_out));
endmodule

// ---- bench/printer_parallel_receiver_tb.sv ----
`timescale 1ns/100ps
module printer_parallel_receiver_tb
  import ppr_pkg::*;
;
  logic i_sys_clk = 0;
  logic i_resetn = 0;
  logic cyc = 0, stb = 0, we = 0, ack, irq, req, lf, clr;
  logic [7:0] adr = '0, pch, last_ch = '0;
  logic [31:0] wdat = '0, wb_q, rd;
  logic sw12 = 1, sw13 = 0, sw18 = 1, sw23 = 0, paper = 0, done = 0, req_d = 0;
  logic offl = 0, merr = 0;
  int fail_count = 0, n_compared = 0, cycles = 0, feeds = 0, n;

  ppr_if lnk ();
  ppr_device #(.LINE_CHARS(4)) ppr_device_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .link(lnk), .i_config_switch_1_2(sw12),
    .i_config_switch_1_3(sw13), .i_config_switch_1_8(sw18), .i_config_switch_2_3(sw23),
    .i_paper_empty(paper), .i_offline(offl), .i_mech_error(merr), .o_print_req(req),
    .o_print_char(pch), .o_line_feed(lf), .i_print_done(done), .o_buffer_clear(clr));
  ppr_host #(.CHAR_CYC(100)) ppr_host_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_dat(wb_q), .o_wb_ack(ack), .o_irq(irq), .link(lnk));
  ppr_link_sva ppr_link_sva_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_data(lnk.data), .i_strobe_n(lnk.strobe_n), .i_restart_n(lnk.restart_n),
    .i_host_select_n(lnk.host_select_n), .i_accept_pulse_n(lnk.accept_pulse_n),
    .i_busy(lnk.busy), .i_paper_out(lnk.paper_out), .i_fault_n(lnk.fault_n));

  // 40 MHz system clock
  always #12.5 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // print mechanism stand-in, done two cycles after each request; also the hang limit
  always @(posedge i_sys_clk)
  begin
    req_d <= req;
    done <= req_d;
    if (req) last_ch <= pch;
    if (lf) feeds <= feeds + 1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, take read data there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_sys_clk); while (ack !== 1'b1);
    rd = wb_q;
    cyc <= 0;
    stb <= 0;
  endtask

  task send(input logic [7:0] c);
    wb(1, REG_DATA, {24'h0, c});
    @(negedge lnk.accept_pulse_n);
    @(posedge lnk.accept_pulse_n);
    repeat (8) @(posedge i_sys_clk);
  endtask

  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // line limit of 4: switch 1-3 off feeds on the fourth character, on does not
  task t_full();
    for (int k = 0; k < 8; k++)
    begin
      sw13 <= (k > 3);
      send(8'h61);
      if (k == 3) chk("full feed", 32'(feeds), 32'h1);
    end
    chk("full no feed", 32'(feeds), 32'h1);
  endtask

  // select line released but fixed by switch 1-8; irq raised, read, cleared
  task t_char();
    wb(1, REG_IRQ_MASK, 32'h3);
    send(8'ha5);
    chk("char", {24'h0, last_ch}, 32'ha5);
    wb(0, REG_STATUS, 0);
    chk("sel", rd, 32'h4);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(0, REG_IRQ_STAT, 0);
    chk("done", rd, 32'h1);
    wb(0, REG_IRQ_STAT, 0);
    chk("cleared", {rd[30:0], irq}, 32'h0);
  endtask

  // carriage return under each switch and auto-feed setting
  task t_feed();
    for (int i = 0; i < 4; i++)
    begin
      sw12 <= (i != 0);
      sw23 <= (i == 3);
      wb(1, REG_CTRL, (i == 2) ? 32'h3 : 32'h2);
      n = feeds;
      send(CHAR_CR);
      chk("cr feed", 32'(feeds - n), 32'(i != 1));
    end
  endtask

  // the done bit left by the feed test is cleared first, so only faults remain
  // each trouble source alone must raise busy and fault; offline also deselects
  task t_fault();
    wb(0, REG_IRQ_STAT, 0);
    chk("feed irq", rd, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      paper <= (i == 0);
      offl <= (i == 1);
      merr <= (i == 2);
      repeat (8) @(posedge i_sys_clk);
      wb(0, REG_STATUS, 0);
      chk("trouble", rd, (i == 0) ? 32'hf : (i == 1) ? 32'h9 : 32'hd);
      wb(0, REG_IRQ_STAT, 0);
      chk("fault irq", rd, 32'h2);
      paper <= 0;
      offl <= 0;
      merr <= 0;
      repeat (8) @(posedge i_sys_clk);
    end
  endtask

  // unselected: the latch is ignored, so only a restart brings the link back
  task t_select();
    sw18 <= 0;
    wb(1, REG_CTRL, 32'h0);
    wb(1, REG_DATA, 32'h41);
    repeat (300) @(posedge i_sys_clk);
    wb(0, REG_STATUS, 0);
    chk("ignored", rd, 32'h10);
    chk("no print", {24'h0, last_ch}, {24'h0, CHAR_CR});
    sw18 <= 1;
    wb(1, REG_CTRL, 32'h4);
    repeat (20) @(posedge i_sys_clk);
    chk("clear", {31'h0, clr}, 32'h1);
    repeat (2100) @(posedge i_sys_clk);
    chk("released", {31'h0, clr}, 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_resetn <= 1;
    t_full();
    t_char();
    t_feed();
    t_fault();
    t_select();
    stop_test();
  end
endmodule
